// File: otpwp_regs.svh
`ifndef OTPWP_REGS_SVH
`define OTPWP_REGS_SVH

// Tap count and midscale default of the device wiper.
`define OTPWP_TAPS 64
`define OTPWP_MIDSCALE 6'h1f
// Strobe pulse counts for store and store-with-lock.
`define OTPWP_PULSES_STORE 4'h6
`define OTPWP_PULSES_LOCK 4'h7
// Minimum select high and low times, in ns.
`define OTPWP_SELECT_HIGH_NS 1000
`define OTPWP_SELECT_LOW_NS 1000
// Settle time after switching the programming supply, in ns.
`define OTPWP_SUPPLY_SETTLE_NS 10000
// Clock period in ns.
`define OTPWP_CLK_NS 10
// Delay counter width.
`define OTPWP_CNT_W 16

`endif

// File: otpwp_pkg.sv
`default_nettype none
package otpwp_pkg;
    // Sequencer states; each step from IDLE to FINISH changes one bit, except to and from MHIGH.
    typedef enum logic [3:0] {
        OTPWP_IDLE = 4'b0000,
        OTPWP_MOVE = 4'b0001,
        OTPWP_ARM = 4'b0011,
        OTPWP_SUPPLY = 4'b0010,
        OTPWP_DROP = 4'b0110,
        OTPWP_PHIGH = 4'b0111,
        OTPWP_PLOW = 4'b0101,
        OTPWP_UNSUPPLY = 4'b0100,
        OTPWP_FINISH = 4'b1100,
        OTPWP_MHIGH = 4'b1000
    } otpwp_state_e;
endpackage
`default_nettype wire

// File: otpwp_delay.sv
`timescale 1ns/1ps
`default_nettype none
`include "otpwp_regs.svh"
// Loadable down counter that flags when a wait has run out.
module otpwp_delay #(
    parameter int CW = `OTPWP_CNT_W
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Load request and count.
    input wire logic load_i,
    input wire logic [CW-1:0] count_i,
    // Wait finished.
    output logic done_o
);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    // Load restarts the wait; otherwise count down to zero.
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (load_i)
            cnt_nxt = count_i;
        else if (cnt_r != '0)
            cnt_nxt = cnt_r - 1'b1;
    end

    // Register the count.
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end

    // Done once the count is exhausted; taken from the register only, so the
    // caller's load decision never loops back through this flag.
    assign done_o = (cnt_r == '0);
endmodule // otpwp_delay
`default_nettype wire

// File: otpwp_programmer.sv
`timescale 1ns/1ps
`default_nettype none
`include "otpwp_regs.svh"
module otpwp_programmer
    import otpwp_pkg::*;
#(
    parameter int HIGH_CYC = (`OTPWP_SELECT_HIGH_NS + `OTPWP_CLK_NS - 1) / `OTPWP_CLK_NS,
    parameter int LOW_CYC = (`OTPWP_SELECT_LOW_NS + `OTPWP_CLK_NS - 1) / `OTPWP_CLK_NS,
    parameter int SETTLE_CYC = (`OTPWP_SUPPLY_SETTLE_NS + `OTPWP_CLK_NS - 1) / `OTPWP_CLK_NS
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // User request.
    input wire logic start_i,
    input wire logic lock_i,
    input wire logic [5:0] target_i,
    input wire logic [5:0] current_i,
    // User status.
    output logic busy_o,
    output logic done_o,
    output logic refused_o,
    // Device pins.
    output logic select_n_o,
    output logic dir_up_o,
    output logic program_voltage_pin_en_o
);
    import otpwp_pkg::*;

    otpwp_state_e st_r, st_nxt;
    logic [5:0] pos_r, pos_nxt, tgt_r, tgt_nxt;
    logic lock_r, lock_nxt, locked_r, locked_nxt;
    logic [3:0] np_r, np_nxt;
    logic busy_nxt, done_nxt, ref_nxt, sel_nxt, dir_nxt, pv_nxt;
    logic ld;
    logic [`OTPWP_CNT_W-1:0] ldv;
    logic tdone;

    otpwp_delay #(.CW(`OTPWP_CNT_W)) u_dly (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .load_i(ld),
        .count_i(ldv),
        .done_o(tdone)
    );

    // Sequencer next state, pin levels and delay loads.
    always_comb
    begin
        st_nxt = st_r;
        pos_nxt = pos_r;
        tgt_nxt = tgt_r;
        lock_nxt = lock_r;
        locked_nxt = locked_r;
        np_nxt = np_r;
        busy_nxt = 1'b1;
        done_nxt = 1'b0;
        ref_nxt = 1'b0;
        sel_nxt = select_n_o;
        dir_nxt = dir_up_o;
        pv_nxt = program_voltage_pin_en_o;
        ld = 1'b0;
        ldv = '0;
        case (st_r)
            OTPWP_IDLE:
            begin
                busy_nxt = 1'b0;
                sel_nxt = 1'b1;
                dir_nxt = 1'b1;
                pv_nxt = 1'b0;
                if (start_i && locked_r)
                    ref_nxt = 1'b1;
                else if (start_i)
                begin
                    pos_nxt = current_i;
                    tgt_nxt = target_i;
                    lock_nxt = lock_i;
                    busy_nxt = 1'b1;
                    st_nxt = OTPWP_MOVE;
                end
            end
            OTPWP_MOVE:
            begin
                // Step the wiper toward the target one tap per pulse.
                if (tdone)
                begin
                    if (pos_r == tgt_r)
                    begin
                        sel_nxt = 1'b1;
                        dir_nxt = 1'b1;
                        ld = 1'b1;
                        ldv = `OTPWP_CNT_W'(HIGH_CYC);
                        st_nxt = OTPWP_ARM;
                    end
                    else
                    begin
                        sel_nxt = 1'b0;
                        dir_nxt = (tgt_r > pos_r);
                        ld = 1'b1;
                        ldv = `OTPWP_CNT_W'(LOW_CYC);
                        st_nxt = OTPWP_MHIGH;
                    end
                end
            end
            OTPWP_MHIGH:
            begin
                // Return select high with direction unchanged: one step, no extra tap.
                if (tdone)
                begin
                    sel_nxt = 1'b1;
                    if (tgt_r > pos_r && pos_r != 6'h3f)
                        pos_nxt = pos_r + 6'h01;
                    else if (tgt_r < pos_r && pos_r != 6'h00)
                        pos_nxt = pos_r - 6'h01;
                    ld = 1'b1;
                    ldv = `OTPWP_CNT_W'(HIGH_CYC);
                    st_nxt = OTPWP_MOVE;
                end
            end
            OTPWP_ARM:
                if (tdone)
                begin
                    pv_nxt = 1'b1;
                    ld = 1'b1;
                    ldv = `OTPWP_CNT_W'(SETTLE_CYC);
                    st_nxt = OTPWP_SUPPLY;
                end
            OTPWP_SUPPLY:
                if (tdone)
                begin
                    sel_nxt = 1'b0;
                    np_nxt = 4'h0;
                    ld = 1'b1;
                    ldv = `OTPWP_CNT_W'(LOW_CYC);
                    st_nxt = OTPWP_DROP;
                end
            OTPWP_DROP, OTPWP_PLOW:
                if (tdone)
                begin
                    if (np_r == (lock_r ? `OTPWP_PULSES_LOCK : `OTPWP_PULSES_STORE))
                    begin
                        pv_nxt = 1'b0;
                        ld = 1'b1;
                        ldv = `OTPWP_CNT_W'(SETTLE_CYC);
                        st_nxt = OTPWP_UNSUPPLY;
                    end
                    else
                    begin
                        sel_nxt = 1'b1;
                        ld = 1'b1;
                        ldv = `OTPWP_CNT_W'(HIGH_CYC);
                        st_nxt = OTPWP_PHIGH;
                    end
                end
            OTPWP_PHIGH:
                if (tdone)
                begin
                    sel_nxt = 1'b0;
                    np_nxt = np_r + 4'h1;
                    ld = 1'b1;
                    ldv = `OTPWP_CNT_W'(LOW_CYC);
                    st_nxt = OTPWP_PLOW;
                end
            OTPWP_UNSUPPLY:
                if (tdone)
                begin
                    sel_nxt = 1'b1;
                    st_nxt = OTPWP_FINISH;
                end
            OTPWP_FINISH:
            begin
                locked_nxt = locked_r | lock_r;
                done_nxt = 1'b1;
                busy_nxt = 1'b0;
                st_nxt = OTPWP_IDLE; // One pulse train per request, never repeated.
            end
            default:
            begin
                sel_nxt = 1'b1;
                pv_nxt = 1'b0;
                st_nxt = OTPWP_IDLE;
            end
        endcase
    end

    // Register the sequencer and all outputs.
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st_r <= OTPWP_IDLE;
            pos_r <= `OTPWP_MIDSCALE;
            tgt_r <= `OTPWP_MIDSCALE;
            lock_r <= 1'b0;
            locked_r <= 1'b0;
            np_r <= 4'h0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            refused_o <= 1'b0;
            select_n_o <= 1'b1;
            dir_up_o <= 1'b1;
            program_voltage_pin_en_o <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            pos_r <= pos_nxt;
            tgt_r <= tgt_nxt;
            lock_r <= lock_nxt;
            locked_r <= locked_nxt;
            np_r <= np_nxt;
            busy_o <= busy_nxt;
            done_o <= done_nxt;
            refused_o <= ref_nxt;
            select_n_o <= sel_nxt;
            dir_up_o <= dir_nxt;
            program_voltage_pin_en_o <= pv_nxt;
        end
    end

    // The first select fall of programming, on entering DROP, must see direction high and supply on.
    chk_supply_before_drop: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (st_r == OTPWP_DROP && $fell(select_n_o)) |-> (program_voltage_pin_en_o && dir_up_o))
        else $error("select fell before supply enabled");

    // After the last pulse the supply is already off while select still stays low.
    chk_supply_off_end: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (st_r == OTPWP_UNSUPPLY) |-> (!program_voltage_pin_en_o && !select_n_o))
        else $error("select rose before supply removed");

    // A pulse high lasts at least two cycles.
    sequence s_rise;
        $rose(select_n_o) && program_voltage_pin_en_o;
    endsequence
    chk_pulse_high_min: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        s_rise |-> select_n_o [*2])
        else $error("select pulse too short");

    // Pulse count matches the request at the end of the pulse train.
    chk_pulse_count: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (st_r == OTPWP_UNSUPPLY && $past(st_r) != OTPWP_UNSUPPLY) |->
        (np_r == (lock_r ? `OTPWP_PULSES_LOCK : `OTPWP_PULSES_STORE)))
        else $error("wrong pulse count");

    // Programming begins with direction and select high.
    chk_arm_levels: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        $rose(program_voltage_pin_en_o) |-> (select_n_o && dir_up_o))
        else $error("supply on without select and direction high");

    // A locked device refuses new requests.
    chk_locked_refuse: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (st_r == OTPWP_IDLE && start_i && locked_r) |=> (refused_o && st_r == OTPWP_IDLE))
        else $error("locked device was driven");

    // Each tracked step moves toward the target, never past it and never wrapping.
    chk_wiper_saturate: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (st_r == OTPWP_MHIGH && tdone) |=>
        (($past(tgt_r) > $past(pos_r)) ? (pos_r > $past(pos_r) && pos_r <= $past(tgt_r))
            : (pos_r < $past(pos_r) && pos_r >= $past(tgt_r))))
        else $error("wiper position wrapped");

    // Done pulses exactly one cycle.
    chk_done_pulse: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        done_o |=> !done_o)
        else $error("done held too long");
endmodule // otpwp_programmer
`default_nettype wire

// File: otpwp_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural potentiometer with a one-time store, driven only by pin edges.
module otpwp_dev_model #(
    parameter int HIGH_NS = 20,
    parameter int LOW_NS = 20
) (
    // Device pins.
    input wire logic select_n_i,
    input wire logic dir_up_i,
    input wire logic pv_en_i,
    // Power cycle request.
    input wire logic por_i,
    // Observed device state.
    output logic [5:0] wiper_o,
    output logic [5:0] store_o,
    output logic programmed_o,
    output logic locked_o,
    output logic [7:0] viol_o
);
    logic [3:0] pulse_cnt;
    logic dir_r;
    logic armed;
    realtime t_edge;

    // The device wakes up unprogrammed at midscale.
    initial
    begin
        wiper_o = 6'h1f;
        store_o = 6'h00;
        programmed_o = 1'b0;
        locked_o = 1'b0;
        viol_o = 8'h00;
        pulse_cnt = 4'h0;
        dir_r = 1'b1;
        armed = 1'b0;
        t_edge = 0.0;
    end

    // Power-up loads the stored tap, else midscale.
    always @(posedge por_i)
    begin
        wiper_o = programmed_o ? store_o : 6'h1f;
    end

    // A select fall with supply off and the device unlocked latches direction and moves one tap, saturating at both ends.
    always @(negedge select_n_i)
    begin
        if (pv_en_i && ($realtime - t_edge) < HIGH_NS) viol_o++;
        t_edge = $realtime;
        #1;
        if (!locked_o && !pv_en_i)
        begin
            dir_r = dir_up_i;
            if (dir_r && wiper_o != 6'h3f) wiper_o++;
            else if (!dir_r && wiper_o != 6'h00) wiper_o--;
        end
    end

    // Each select rise under supply counts one programming pulse while the device is unlocked.
    always @(posedge select_n_i)
    begin
        if (pv_en_i && !locked_o)
        begin
            if (($realtime - t_edge) < LOW_NS) viol_o++;
            pulse_cnt++;
        end
        t_edge = $realtime;
    end

    // Supply must arrive with both control pins high.
    always @(posedge pv_en_i)
    begin
        if (!select_n_i || !dir_up_i) viol_o++;
        armed = 1'b1;
    end

    // Supply removal after six or more pulses commits the store; a seventh pulse also locks.
    // The pin settling low out of reset is not a removal and is ignored.
    always @(negedge pv_en_i)
    begin
        if (armed)
        begin
            if (select_n_i) viol_o++;
            if (pulse_cnt >= 4'h6)
            begin
                store_o = store_o | wiper_o;
                programmed_o = 1'b1;
            end
            if (pulse_cnt >= 4'h7) locked_o = 1'b1;
        end
        armed = 1'b0;
        pulse_cnt = 4'h0;
    end
endmodule // otpwp_dev_model
`default_nettype wire

// File: otpwp_programmer_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench: controller against the device model.
module otpwp_programmer_tb;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic start_i = 1'b0;
    logic lock_i = 1'b0;
    logic [5:0] target_i = 6'h00;
    logic [5:0] current_i = 6'h00;
    logic por = 1'b0;
    logic busy_o, done_o, refused_o, select_n_o, dir_up_o, pv_en;
    logic [5:0] wiper, store, t1, t2;
    logic programmed, locked, seen;
    logic [7:0] viol;
    int error_cnt = 0;
    int checks = 0;
    int seed = 32'hd2a3;

    // Free-running 100 MHz clock.
    always #5 ref_clk_i = ~ref_clk_i;

    otpwp_programmer #(.HIGH_CYC(2), .LOW_CYC(2), .SETTLE_CYC(4)) dut (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .start_i(start_i), .lock_i(lock_i),
        .target_i(target_i), .current_i(current_i), .busy_o(busy_o), .done_o(done_o),
        .refused_o(refused_o), .select_n_o(select_n_o), .dir_up_o(dir_up_o),
        .program_voltage_pin_en_o(pv_en));

    otpwp_dev_model #(.HIGH_NS(20), .LOW_NS(20)) dev (
        .select_n_i(select_n_o), .dir_up_i(dir_up_o), .pv_en_i(pv_en), .por_i(por),
        .wiper_o(wiper), .store_o(store), .programmed_o(programmed),
        .locked_o(locked), .viol_o(viol));

    // Compares one value and reports a mismatch.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Requests one programming run and waits for its end.
    task automatic run(input logic lk, input logic [5:0] tg, input logic [5:0] cur);
        int n;
        @(posedge ref_clk_i);
        start_i <= 1'b1;
        lock_i <= lk;
        target_i <= tg;
        current_i <= cur;
        @(posedge ref_clk_i);
        start_i <= 1'b0;
        #1;
        chk(busy_o, 8'h01);
        n = 0;
        while (done_o !== 1'b1 && n < 5000)
        begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        if (n >= 5000)
        begin
            error_cnt++;
            final_report();
        end
        chk(busy_o, 8'h00);
        chk(select_n_o, 8'h01);
        chk(pv_en, 8'h00);
        chk(dir_up_o, 8'h01);
    endtask

    // Cycles the device power.
    task automatic power_cycle();
        @(posedge ref_clk_i);
        por <= 1'b1;
        @(posedge ref_clk_i);
        por <= 1'b0;
        #1;
    endtask

    // Main sequence.
    initial
    begin
        repeat (12) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        #1;
        chk(wiper, 8'h1f);
        t1 = 6'($random(seed));
        run(1'b0, t1, wiper);
        chk(wiper, t1);
        chk(store, t1);
        chk(programmed, 8'h01);
        chk(locked, 8'h00);
        power_cycle();
        chk(wiper, t1);
        $display("test 1 six-pulse store done");
        t2 = 6'($random(seed));
        run(1'b0, t2, wiper);
        chk(store, t1 | t2);
        power_cycle();
        chk(wiper, t1 | t2);
        $display("test 2 repeat store done");
        run(1'b0, 6'h00, 6'h3f);
        chk(wiper, 8'h00);
        run(1'b0, 6'h3f, 6'h00);
        chk(wiper, 8'h3f);
        chk(store, 8'h3f);
        $display("test 3 saturation done");
        t1 = 6'($random(seed));
        run(1'b1, t1, wiper);
        chk(locked, 8'h01);
        t2 = wiper;
        @(posedge ref_clk_i);
        start_i <= 1'b1;
        @(posedge ref_clk_i);
        start_i <= 1'b0;
        seen = 1'b0;
        // The refusal pulse stands for the cycle right after the request is taken.
        repeat (8)
        begin
            #1;
            if (refused_o === 1'b1) seen = 1'b1;
            @(posedge ref_clk_i);
        end
        #1;
        chk(seen, 8'h01);
        chk(select_n_o, 8'h01);
        chk(pv_en, 8'h00);
        chk(wiper, t2);
        $display("test 4 lock done");
        chk(viol, 8'h00);
        final_report();
    end
endmodule // otpwp_programmer_tb
`default_nettype wire
